/* src/pe_fmt_pkg.sv */
package pe_fmt_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_FCNT = 4'h8;
  localparam int CTRL_FN_DATA = 0;
  localparam int CTRL_FN_MARK = 1;
  localparam int CTRL_PAR_ODD = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CNT_W = 21;
  localparam logic [20:0] PRE_CHARS = 21'h000028;
  localparam logic [20:0] POST_END = 21'h000050;
  localparam logic [15:0] FCNT_RST = 16'h0000;
  localparam logic [8:0] ZERO_CHAR = 9'h000;
  localparam logic [8:0] SELECT_A_CHAR = 9'h1FF;
  localparam logic [8:0] MARK_CLR_MASK = 9'h0D8;
  localparam logic [8:0] IDB_CLR_MASK = 9'h0FF;
  localparam int IDB_ON_NS = 20000;
  localparam int IDB_ON_CYC = (IDB_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDB_LEN_MS = 64;
  localparam int IDB_LEN_CYC = IDB_LEN_MS * 1000000 / CLK_PERIOD_NS;
  localparam int IDB_DELAY_MS = 74;
  localparam int IDB_DELAY_CYC = IDB_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int START_DELAY_CYC = 2000;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ACCEL = 7'h02,
    ST_PRE0 = 7'h04,
    ST_PRE1 = 7'h08,
    ST_DATA = 7'h10,
    ST_POS1 = 7'h20,
    ST_POS0 = 7'h40
  } fmt_state_t;
endpackage

/* src/pe_tape_write_formatter.sv */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module pe_tape_write_formatter #(
  parameter int START_DELAY_CYC = pe_fmt_pkg::START_DELAY_CYC,
  parameter int IDB_DELAY_CYC = pe_fmt_pkg::IDB_DELAY_CYC,
  parameter int IDB_LEN_CYC = pe_fmt_pkg::IDB_LEN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic run,
  input wire logic [7:0] disassembled_char_lines,
  output logic data_char_strobe,
  output logic frame_count_increment,
  input wire logic transport_write_clock,
  input wire logic load_point,
  output logic [8:0] write_data_lines,
  output logic record_strobe,
  output logic write_command,
  output logic forward_command,
  output logic slave_set_pulse,
  output logic heads_energized,
  output logic accelerating_flag,
  output logic id_burst_flag
);
  typedef struct packed {
    logic [2:0] wsync;
    logic [1:0] lpsync;
    logic run_q;
    pe_fmt_pkg::fmt_state_t st;
    logic [20:0] cnt;
    logic half;
    logic [8:0] wbuf;
    logic wrf;
    logic mark;
    logic identification_burst;
    logic idb_mode;
    logic idb_par;
    logic fn_data;
    logic fn_mark;
    logic par_odd;
    logic [15:0] fcnt;
    logic rec;
    logic dstrb;
    logic fcinc;
    logic sset;
    logic wcmd;
    logic heads;
    logic accel;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [3:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } fmt_regs_t;

  fmt_regs_t s_r;
  fmt_regs_t s_nxt;

  function automatic logic [8:0] fmt_force(input logic [8:0] v, input logic mark, input logic identification_burst);
    logic [8:0] r;
    r = v;
    if (mark) begin
      r = r & ~pe_fmt_pkg::MARK_CLR_MASK;
    end
    if (identification_burst) begin
      r = r & ~pe_fmt_pkg::IDB_CLR_MASK;
    end
    return r;
  endfunction

  always_comb begin
    logic wclk_edge;
    logic run_rise;
    logic buf_en;
    logic [8:0] mux;
    logic [20:0] cnt_inc;
    logic [15:0] fcnt_inc;
    wclk_edge = 1'b0;
    run_rise = 1'b0;
    buf_en = 1'b0;
    mux = pe_fmt_pkg::ZERO_CHAR;
    cnt_inc = s_r.cnt + 21'h000001;
    fcnt_inc = s_r.fcnt + 16'h0001;
    s_nxt = s_r;
    s_nxt.rec = 1'b0;
    s_nxt.dstrb = 1'b0;
    s_nxt.fcinc = 1'b0;
    s_nxt.sset = 1'b0;
    // The write clock is asynchronous; edges are found after two stages.
    s_nxt.wsync = {s_r.wsync[1:0], transport_write_clock};
    s_nxt.lpsync = {s_r.lpsync[0], load_point};
    wclk_edge = s_r.wsync[1] & ~s_r.wsync[2];
    run_rise = run & ~s_r.run_q;
    s_nxt.run_q = run;

    if (awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdat = wdata;
      s_nxt.wstb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = pe_fmt_pkg::RESP_OKAY;
      case ({s_r.waddr[3:2], 2'b00})
        pe_fmt_pkg::OFF_CTRL: begin
          // Functions change only between records, so a busy write is dropped.
          if (s_r.wstb[0] && s_r.st == pe_fmt_pkg::ST_IDLE) begin
            s_nxt.fn_data = s_r.wdat[pe_fmt_pkg::CTRL_FN_DATA];
            s_nxt.fn_mark = s_r.wdat[pe_fmt_pkg::CTRL_FN_MARK] & ~s_r.wdat[pe_fmt_pkg::CTRL_FN_DATA];
            s_nxt.par_odd = s_r.wdat[pe_fmt_pkg::CTRL_PAR_ODD];
          end
        end
        pe_fmt_pkg::OFF_STAT: begin
        end
        pe_fmt_pkg::OFF_FCNT: begin
          if (s_r.wstb[0]) begin
            s_nxt.fcnt[7:0] = s_r.wdat[7:0];
          end
          if (s_r.wstb[1]) begin
            s_nxt.fcnt[15:8] = s_r.wdat[15:8];
          end
        end
        default: begin
          s_nxt.bresp = pe_fmt_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = pe_fmt_pkg::RESP_OKAY;
      case ({araddr[3:2], 2'b00})
        pe_fmt_pkg::OFF_CTRL: s_nxt.rdata = {29'h00000000, s_r.par_odd, s_r.fn_mark, s_r.fn_data};
        pe_fmt_pkg::OFF_STAT: s_nxt.rdata = {20'h00000, s_r.lpsync[1], s_r.accel, s_r.identification_burst, s_r.mark, s_r.wrf, s_r.st};
        pe_fmt_pkg::OFF_FCNT: s_nxt.rdata = {16'h0000, s_r.fcnt};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = pe_fmt_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (run_rise && s_r.st == pe_fmt_pkg::ST_IDLE && (s_r.fn_data || s_r.fn_mark)) begin
      s_nxt.sset = 1'b1;
      s_nxt.wrf = s_r.fn_data;
      s_nxt.mark = s_r.fn_mark;
      s_nxt.heads = 1'b1;
      s_nxt.idb_mode = s_r.fn_data & s_r.lpsync[1];
      s_nxt.st = pe_fmt_pkg::ST_ACCEL;
      s_nxt.cnt = '0;
      s_nxt.half = 1'b0;
    end

    if (s_r.st == pe_fmt_pkg::ST_ACCEL) begin
      s_nxt.cnt = cnt_inc;
      if (s_r.idb_mode) begin
        if (s_r.cnt == 21'(pe_fmt_pkg::IDB_ON_CYC)) begin
          s_nxt.identification_burst = 1'b1;
        end
        if (s_r.cnt == 21'(pe_fmt_pkg::IDB_ON_CYC + IDB_LEN_CYC)) begin
          s_nxt.identification_burst = 1'b0;
        end
      end
      if ((s_r.idb_mode && s_r.cnt == 21'(IDB_DELAY_CYC)) || (!s_r.idb_mode && s_r.cnt == 21'(START_DELAY_CYC))) begin
        s_nxt.st = pe_fmt_pkg::ST_PRE0;
        s_nxt.cnt = '0;
        s_nxt.half = 1'b0;
        s_nxt.identification_burst = 1'b0;
      end
    end

    buf_en = s_r.identification_burst || (s_r.st != pe_fmt_pkg::ST_IDLE && s_r.st != pe_fmt_pkg::ST_ACCEL);

    case (s_r.st)
      pe_fmt_pkg::ST_PRE1: mux = pe_fmt_pkg::SELECT_A_CHAR;
      pe_fmt_pkg::ST_POS1: mux = pe_fmt_pkg::SELECT_A_CHAR;
      pe_fmt_pkg::ST_DATA: mux = {(^disassembled_char_lines) ^ s_r.par_odd, disassembled_char_lines};
      default: mux = pe_fmt_pkg::ZERO_CHAR;
    endcase
    if (s_r.identification_burst) begin
      mux[8] = s_r.idb_par;
    end

    if (wclk_edge && buf_en) begin
      s_nxt.rec = 1'b1;
      if (!s_r.half) begin
        s_nxt.wbuf = fmt_force(mux, s_r.mark, s_r.identification_burst);
        s_nxt.half = 1'b1;
        if (s_r.st == pe_fmt_pkg::ST_DATA) begin
          s_nxt.dstrb = 1'b1;
          s_nxt.fcinc = 1'b1;
          s_nxt.fcnt = fcnt_inc;
          if (fcnt_inc == 16'h0000) begin
            s_nxt.wrf = 1'b0;
          end
        end
      end else begin
        s_nxt.wbuf = fmt_force(~s_r.wbuf, s_r.mark, s_r.identification_burst);
        s_nxt.half = 1'b0;
        if (s_r.identification_burst) begin
          s_nxt.idb_par = ~s_r.idb_par;
        end
        case (s_r.st)
          pe_fmt_pkg::ST_PRE0: begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc == pe_fmt_pkg::PRE_CHARS) begin
              if (s_r.mark) begin
                s_nxt.st = pe_fmt_pkg::ST_IDLE;
                s_nxt.mark = 1'b0;
                s_nxt.heads = 1'b0;
                s_nxt.fn_mark = 1'b0;
              end else begin
                s_nxt.st = pe_fmt_pkg::ST_PRE1;
              end
            end
          end
          pe_fmt_pkg::ST_PRE1: s_nxt.st = pe_fmt_pkg::ST_DATA;
          pe_fmt_pkg::ST_DATA: begin
            if (!s_nxt.wrf) begin
              s_nxt.st = pe_fmt_pkg::ST_POS1;
            end
          end
          pe_fmt_pkg::ST_POS1: begin
            s_nxt.st = pe_fmt_pkg::ST_POS0;
            s_nxt.cnt = pe_fmt_pkg::PRE_CHARS;
          end
          pe_fmt_pkg::ST_POS0: begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc == pe_fmt_pkg::POST_END) begin
              s_nxt.st = pe_fmt_pkg::ST_IDLE;
              s_nxt.heads = 1'b0;
              s_nxt.fn_data = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    s_nxt.wcmd = s_nxt.fn_data | s_nxt.fn_mark;
    s_nxt.accel = (s_nxt.st == pe_fmt_pkg::ST_ACCEL) && !s_nxt.identification_burst;
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= pe_fmt_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;
  assign data_char_strobe = s_r.dstrb;
  assign frame_count_increment = s_r.fcinc;
  assign write_data_lines = s_r.wbuf;
  assign record_strobe = s_r.rec;
  assign write_command = s_r.wcmd;
  assign forward_command = s_r.wcmd;
  assign slave_set_pulse = s_r.sset;
  assign heads_energized = s_r.heads;
  assign accelerating_flag = s_r.accel;
  assign id_burst_flag = s_r.identification_burst;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_parity;
    s_r.dstrb |-> ((^s_r.wbuf) == s_r.par_odd);
  endproperty
  a_parity: assert property (p_parity) else $error("Data character parity has the wrong sense.");

  property p_complement;
    (s_r.rec && !s_r.half && s_r.st == pe_fmt_pkg::ST_DATA) |-> (s_r.wbuf == ~$past(s_r.wbuf));
  endproperty
  a_complement: assert property (p_complement) else $error("Second half is not the complement.");

  sequence s_drive_set;
    run && !$past(run) && s_r.st == pe_fmt_pkg::ST_IDLE && s_r.fn_data;
  endsequence
  sequence s_motion_start;
    ##1 (s_r.sset && s_r.wrf && s_r.st == pe_fmt_pkg::ST_ACCEL) ##1 !s_r.sset;
  endsequence
  property p_run_start;
    s_drive_set |-> s_motion_start;
  endproperty
  a_run_start: assert property (p_run_start) else $error("Run did not start a data record.");

  property p_accel_quiet;
    (s_r.st == pe_fmt_pkg::ST_ACCEL && s_r.rec) |-> $past(s_r.identification_burst);
  endproperty
  a_accel_quiet: assert property (p_accel_quiet) else $error("Record strobe during acceleration.");

  property p_pre_no_strobe;
    (s_r.st != pe_fmt_pkg::ST_DATA && $past(s_r.st) != pe_fmt_pkg::ST_DATA) |-> !s_r.dstrb;
  endproperty
  a_pre_no_strobe: assert property (p_pre_no_strobe) else $error("Data strobe outside the data state.");

  property p_pre_count;
    (s_r.st == pe_fmt_pkg::ST_PRE1 && $past(s_r.st) == pe_fmt_pkg::ST_PRE0) |-> $past(s_r.cnt) == 21'h000027;
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("Preamble did not hold forty zeros.");

  property p_write_end;
    $fell(s_r.wrf) |-> (s_r.fcnt == 16'h0000 || s_r.st == pe_fmt_pkg::ST_IDLE);
  endproperty
  a_write_end: assert property (p_write_end) else $error("Write record flag fell without overflow.");

  property p_post_end;
    (s_r.st == pe_fmt_pkg::ST_IDLE && $past(s_r.st) == pe_fmt_pkg::ST_POS0) |-> $past(s_r.cnt) == 21'h00004F;
  endproperty
  a_post_end: assert property (p_post_end) else $error("Postamble did not end at count_reached_80.");

  property p_mark_mask;
    (s_r.rec && s_r.mark) |-> ((s_r.wbuf & pe_fmt_pkg::MARK_CLR_MASK) == 9'h000);
  endproperty
  a_mark_mask: assert property (p_mark_mask) else $error("Tape mark left a forced bit set.");

  property p_mark_stop;
    $fell(s_r.mark) |=> !s_r.rec [*8];
  endproperty
  a_mark_stop: assert property (p_mark_stop) else $error("Strobes continued after the tape mark.");

  property p_idb_accel;
    s_r.identification_burst |-> !s_r.accel;
  endproperty
  a_idb_accel: assert property (p_idb_accel) else $error("Acceleration shown during the burst.");

  property p_idb_bits;
    (s_r.rec && $past(s_r.identification_burst)) |-> (s_r.wbuf[7:0] == 8'h00);
  endproperty
  a_idb_bits: assert property (p_idb_bits) else $error("Burst character has data bits set.");

  property p_strobe_spacing;
    s_r.dstrb |=> !s_r.dstrb [*3];
  endproperty
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("Data strobes too close together.");
endmodule

/* verif/tape_transport_model.sv */
`timescale 1ns/1ns
module tape_transport_model (
  input wire logic aclk,
  input wire logic slave_set_pulse,
  input wire logic heads_energized,
  input wire logic accelerating_flag,
  input wire logic id_burst_flag,
  input wire logic record_strobe,
  input wire logic [8:0] write_data_lines,
  output logic transport_write_clock
);
  logic moving = 1'b0;
  // A strobe trails the burst flag that enabled it by one cycle, so the stored mark is delayed to match.
  logic idb_q = 1'b0;
  logic [9:0] rec_q[$];
  // The clock stands low outside a record, so a stray edge cannot hide there.
  initial begin
    transport_write_clock = 1'b0;
    #7;
    forever begin
      #160;
      transport_write_clock = (moving && !accelerating_flag) ? !transport_write_clock : 1'b0;
    end
  end
  always @(posedge aclk) begin
    if (slave_set_pulse) begin
      moving <= 1'b1;
    end else if (!heads_energized) begin
      moving <= 1'b0;
    end
    if (record_strobe) begin
      rec_q.push_back({idb_q, write_data_lines});
    end
    idb_q <= id_burst_flag;
  end
endmodule

/* verif/pe_tape_write_formatter_test.sv */
`timescale 1ns/1ns
module pe_tape_write_formatter_test;
  localparam int IDB_LEN = 2000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, run = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] disassembled_char_lines = 8'h00;
  logic load_point = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, data_char_strobe, frame_count_increment;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic transport_write_clock, record_strobe, write_command, forward_command;
  logic slave_set_pulse, heads_energized, accelerating_flag, id_burst_flag;
  logic [8:0] write_data_lines;
  logic [7:0] chars[4] = '{8'hA5, 8'h3C, 8'h01, 8'hFF};
  logic [1:0] dptr = 2'h0;
  logic [8:0] exp_q[$];
  int num_errors = 0, n_tests = 0, nstr = 0, nfc = 0, idb_cyc = 0, bad_acc = 0;

  always #20 aclk = ~aclk;

  pe_tape_write_formatter #(.START_DELAY_CYC(20), .IDB_DELAY_CYC(3000), .IDB_LEN_CYC(IDB_LEN)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .run(run),
    .disassembled_char_lines(disassembled_char_lines), .data_char_strobe(data_char_strobe),
    .frame_count_increment(frame_count_increment), .transport_write_clock(transport_write_clock),
    .load_point(load_point), .write_data_lines(write_data_lines), .record_strobe(record_strobe),
    .write_command(write_command), .forward_command(forward_command),
    .slave_set_pulse(slave_set_pulse), .heads_energized(heads_energized),
    .accelerating_flag(accelerating_flag), .id_burst_flag(id_burst_flag));

  tape_transport_model xport (
    .aclk(aclk), .slave_set_pulse(slave_set_pulse), .heads_energized(heads_energized),
    .accelerating_flag(accelerating_flag), .id_burst_flag(id_burst_flag),
    .record_strobe(record_strobe), .write_data_lines(write_data_lines),
    .transport_write_clock(transport_write_clock));

  // The next character is offered as soon as the current one is requested.
  always @(posedge aclk) begin
    if (data_char_strobe) begin
      nstr++;
      dptr <= dptr + 2'h1;
    end
    disassembled_char_lines <= chars[data_char_strobe ? dptr + 2'h1 : dptr];
    if (frame_count_increment) nfc++;
    if (id_burst_flag) idb_cyc++;
    if (id_burst_flag && accelerating_flag) bad_acc++;
  end

  task automatic end_of_test;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    check("bvalid", 32'h1, {31'h0, bvalid});
    check("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    check("rvalid", 32'h1, {31'h0, rvalid});
    check("rdata", e, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  task automatic pe(input logic [8:0] x, input logic [8:0] m);
    exp_q.push_back(x & ~m);
    exp_q.push_back(~x & ~m);
  endtask

  task automatic run_record(input logic [31:0] ctrl, input int n, input logic lp);
    int j;
    int ni;
    logic pq;
    logic [9:0] q;
    logic [7:0] c;
    load_point <= lp;
    wr(pe_fmt_pkg::OFF_FCNT, 32'h10000 - n, pe_fmt_pkg::RESP_OKAY);
    wr(pe_fmt_pkg::OFF_CTRL, ctrl, pe_fmt_pkg::RESP_OKAY);
    if (ctrl[0]) check("commands", 32'h3, {write_command, forward_command});
    xport.rec_q.delete();
    nstr = 0;
    nfc = 0;
    dptr <= 2'h0;
    run <= 1'b1;
    for (int i = 0; i < 8 && !slave_set_pulse; i++) @(posedge aclk);
    check("slave set", 32'h3, {slave_set_pulse, heads_energized});
    run <= 1'b0;
    wr(pe_fmt_pkg::OFF_CTRL, 32'h2, pe_fmt_pkg::RESP_OKAY);
    rd(pe_fmt_pkg::OFF_CTRL, ctrl, pe_fmt_pkg::RESP_OKAY);
    for (int i = 0; i < 20000 && heads_energized; i++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    exp_q.delete();
    if (ctrl[0]) begin
      for (int i = 0; i < 40; i++) pe(pe_fmt_pkg::ZERO_CHAR, 9'h000);
      pe(pe_fmt_pkg::SELECT_A_CHAR, 9'h000);
      for (int i = 0; i < n; i++) begin
        c = chars[i];
        pe({^c ^ ctrl[2], c}, 9'h000);
      end
      pe(pe_fmt_pkg::SELECT_A_CHAR, 9'h000);
      for (int i = 0; i < 40; i++) pe(pe_fmt_pkg::ZERO_CHAR, 9'h000);
    end else begin
      for (int i = 0; i < 40; i++) pe(pe_fmt_pkg::ZERO_CHAR, pe_fmt_pkg::MARK_CLR_MASK);
    end
    j = 0;
    ni = 0;
    pq = 1'b0;
    foreach (xport.rec_q[k]) begin
      q = xport.rec_q[k];
      if (q[9]) begin
        if (ni > 0) check("burst parity", {31'h0, ni[0] ? ~pq : pq}, {31'h0, q[8]});
        check("burst bits", 32'h0, {24'h0, q[7:0]});
        pq = q[8];
        ni++;
      end else begin
        if (j < exp_q.size()) check("tape char", {23'h0, exp_q[j]}, {23'h0, q[8:0]});
        j++;
      end
    end
    check("strobes", exp_q.size(), j);
    check("burst seen", {31'h0, lp}, {31'h0, ni > 0});
    check("data strobes", n, nstr);
    check("frame incs", n, nfc);
    rd(pe_fmt_pkg::OFF_FCNT, ctrl[0] ? 32'h0 : (32'h10000 - n) & 32'hFFFF, pe_fmt_pkg::RESP_OKAY);
    rd(pe_fmt_pkg::OFF_STAT, {20'h0, lp, 11'h001}, pe_fmt_pkg::RESP_OKAY);
  endtask

  // Rows: control word and character count; even, odd, tape mark.
  logic [31:0] row_ctrl[3] = '{32'h1, 32'h5, 32'h2};
  int row_n[3] = '{3, 2, 0};

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check("idle outputs", 32'h0, {write_data_lines, record_strobe, slave_set_pulse, heads_energized,
      accelerating_flag, id_burst_flag, data_char_strobe});
    rd(pe_fmt_pkg::OFF_STAT, 32'h001, pe_fmt_pkg::RESP_OKAY);
    rd(pe_fmt_pkg::OFF_CTRL, 32'h0, pe_fmt_pkg::RESP_OKAY);
    rd(4'hC, 32'h0, pe_fmt_pkg::RESP_SLVERR);
    wr(4'hC, 32'h1, pe_fmt_pkg::RESP_SLVERR);
    for (int r = 0; r < 3; r++) run_record(row_ctrl[r], row_n[r], 1'b0);
    idb_cyc = 0;
    run_record(32'h1, 1, 1'b1);
    check("burst length", IDB_LEN, idb_cyc);
    check("accel in burst", 32'h0, bad_acc);
    end_of_test();
  end

  // Four records at well under ten thousand cycles; the limit leaves ample margin.
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end
endmodule
